// >>> hdl/rtc_pkg.sv
// Constants, field layouts and calendar helper functions for the BCD calendar clock.
package rtc_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int FAST_DIV = 32;
  localparam int FAST_DIV_W = 5;
  localparam int PREDIV_A_W = 7;
  localparam int PREDIV_S_W = 15;
  localparam int SHIFT_W = 15;
  localparam int WAKE_W = 17;
  localparam int WAKE_RELOAD_W = 16;
  localparam int WAKE_SEL_W = 3;
  localparam int WAKE_DIV_W = 4;
  localparam int BKP_DEPTH = 32;
  localparam int BKP_AW = 5;
  localparam int BKP_DW = 32;
  // One inserted or masked pulse per 2^20 kernel pulses gives a 0.95 ppm step.
  localparam int CAL_W         = 20;
  localparam int CAL_SUB_W     = 11;
  localparam int CALM_W        = 9;
  localparam int REF_CNT_W     = 6;
  localparam logic [REF_CNT_W-1:0] REF_LAST_50 = 6'h31;
  localparam logic [REF_CNT_W-1:0] REF_LAST_60 = 6'h3b;
  localparam int FILT_W        = 2;
  localparam int TFCNT_W       = 4;
  localparam int NUM_TAMP      = 3;

  // ---------------------------------------------------------------------------
  // Calendar field layout
  // ---------------------------------------------------------------------------
  localparam int T_SEC_LSB = 0;
  localparam int T_MIN_LSB = 7;
  localparam int T_HR_LSB  = 14;
  localparam int T_PM_BIT  = 20;
  localparam int TIME_W    = 21;
  localparam int SEC_W     = 7;
  localparam int HR_W      = 6;
  localparam int D_DAY_LSB = 0;
  localparam int D_WD_LSB  = 6;
  localparam int D_MON_LSB = 9;
  localparam int D_YR_LSB  = 14;
  localparam int DATE_W    = 22;
  localparam int DAY_W     = 6;
  localparam int WD_W      = 3;
  localparam int MON_W     = 5;
  localparam int YR_W      = 8;
  localparam logic [TIME_W-1:0] TIME_RST = 21'h000000;
  localparam logic [DATE_W-1:0] DATE_RST = 22'h000241;

  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [WD_W-1:0] WD_FIRST = 3'h1;
  localparam logic [WD_W-1:0] WD_LAST  = 3'h7;

  // ---------------------------------------------------------------------------
  // Codes and flag positions
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CKSEL_NONE = 2'h0;
  localparam logic [1:0] CKSEL_LSC  = 2'h1;
  localparam logic [1:0] CKSEL_RC   = 2'h2;
  localparam logic [1:0] CKSEL_FAST = 2'h3;
  localparam int FLG_ALRA = 0;
  localparam int FLG_ALRB = 1;
  localparam int FLG_WAKE = 2;
  localparam int FLG_TS   = 3;
  localparam int FLG_TAMP = 4;
  localparam int NUM_FLAGS = 7;
  localparam int PIN_LSC  = 0;
  localparam int PIN_RC   = 1;
  localparam int PIN_FAST = 2;
  localparam int PIN_REF  = 3;
  localparam int PIN_TS   = 4;
  localparam int PIN_VBAT = 5;
  localparam int PIN_TAMP = 6;
  localparam int PIN_W    = 9;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    case (mon)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

endpackage

// >>> hdl/bcd_calendar_rtc_backup.sv
// BCD calendar clock with alarms, tamper, timestamp, wakeup timer and backup store.
// Function
// RQ1 - BCD calendar, subseconds, 12 or 24 hours
// RQ2 - Month lengths 28, 29 leap, 30, 31
// RQ3 - Shift time base by 1 to 32767 pulses
// RQ4 - Align seconds to 50 or 60 Hz reference
// RQ5 - Digital calibration in 0.95 ppm steps
// RQ6 - Three filtered tamper inputs raise flags
// RQ7 - Timestamp on pin, tamper or battery switch
// RQ8 - 17-bit auto-reload periodic wakeup counter
// RQ9 - 128 bytes backup store, 32-bit words
// RQ10 - Only backup-domain reset clears backup store
// RQ11 - Kernel clock: crystal, RC, or fast/32
// RQ12 - Every event raises interrupt and wakeup request
// RQ13 - Prescaler chain makes 1 Hz and subseconds
`timescale 1ns/1ps
module bcd_calendar_rtc_backup (
  input  wire  logic                              clk_sys,
  input  wire  logic                              reset_n,
  input  wire  logic                              clk_en,
  input  wire  logic [1:0]                        clk_sel,
  input  wire  logic                              low_speed_crystal_clock,
  input  wire  logic                              low_speed_internal_rc_clock,
  input  wire  logic                              high_speed_external_clock,
  input  wire  logic [rtc_pkg::PREDIV_A_W-1:0]    prediv_a,
  input  wire  logic [rtc_pkg::PREDIV_S_W-1:0]    prediv_s,
  input  wire  logic                              hour_12_mode,
  input  wire  logic                              time_load,
  input  wire  logic [rtc_pkg::TIME_W-1:0]        time_load_value,
  input  wire  logic [rtc_pkg::DATE_W-1:0]        date_load_value,
  input  wire  logic                              shift_req,
  input  wire  logic                              shift_add_second,
  input  wire  logic [rtc_pkg::SHIFT_W-1:0]       shift_count,
  input  wire  logic                              ref_detect_en,
  input  wire  logic                              ref_60hz,
  input  wire  logic                              ref_clock_pin,
  input  wire  logic                              cal_plus,
  input  wire  logic [rtc_pkg::CALM_W-1:0]        cal_minus,
  input  wire  logic                              alarm_a_en,
  input  wire  logic [rtc_pkg::TIME_W-1:0]        alarm_a_value,
  input  wire  logic                              alarm_b_en,
  input  wire  logic [rtc_pkg::TIME_W-1:0]        alarm_b_value,
  input  wire  logic [rtc_pkg::NUM_TAMP-1:0]      tamper_pin,
  input  wire  logic [rtc_pkg::NUM_TAMP-1:0]      tamper_en,
  input  wire  logic [rtc_pkg::FILT_W-1:0]        tamper_filter,
  input  wire  logic                              timestamp_pin,
  input  wire  logic                              timestamp_en,
  input  wire  logic                              vbat_switch_pin,
  input  wire  logic                              wakeup_en,
  input  wire  logic [rtc_pkg::WAKE_SEL_W-1:0]    wakeup_clk_sel,
  input  wire  logic [rtc_pkg::WAKE_RELOAD_W-1:0] wakeup_reload,
  input  wire  logic [rtc_pkg::NUM_FLAGS-1:0]     flag_clear,
  input  wire  logic [rtc_pkg::NUM_FLAGS-1:0]     irq_en,
  input  wire  logic                              backup_we,
  input  wire  logic [rtc_pkg::BKP_AW-1:0]        backup_addr,
  input  wire  logic [rtc_pkg::BKP_DW-1:0]        backup_wdata,
  output logic       [rtc_pkg::BKP_DW-1:0]        backup_rdata,
  output logic       [rtc_pkg::TIME_W-1:0]        time_bcd,
  output logic       [rtc_pkg::DATE_W-1:0]        date_bcd,
  output logic       [rtc_pkg::PREDIV_S_W-1:0]    subsecond,
  output logic       [rtc_pkg::TIME_W-1:0]        ts_time_bcd,
  output logic       [rtc_pkg::DATE_W-1:0]        ts_date_bcd,
  output logic       [rtc_pkg::PREDIV_S_W-1:0]    ts_subsecond,
  output logic       [rtc_pkg::NUM_FLAGS-1:0]     flags,
  output logic                                    shift_busy,
  output logic                                    irq,
  output logic                                    wakeup_req
);
  import rtc_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Pins are sampled on clk_sys, so the fast source must stay under a quarter of it.
  logic [PIN_W-1:0] pins, sync1_q, sync2_q, sync3_q, rise;

  assign pins = {tamper_pin, vbat_switch_pin, timestamp_pin, ref_clock_pin, high_speed_external_clock,
                 low_speed_internal_rc_clock, low_speed_crystal_clock};
  assign rise = sync2_q & ~sync3_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (clk_en) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Kernel clock selection and calibration
  // ---------------------------------------------------------------------------
  logic [FAST_DIV_W-1:0] fast_div_q;
  logic [CAL_W-1:0]      cal_cnt_q;
  logic                  ins_pend_q;
  logic [SHIFT_W-1:0]    shift_pend_q;
  logic                  raw_pulse, cal_window, cal_mask, kpulse, kpulse_cal;

  always_comb begin
    unique case (clk_sel) // RQ11
      CKSEL_LSC:  raw_pulse = rise[PIN_LSC];
      CKSEL_RC:   raw_pulse = rise[PIN_RC];
      CKSEL_FAST: raw_pulse = rise[PIN_FAST] && fast_div_q == FAST_DIV_W'(FAST_DIV - 1);
      default:    raw_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fast_div_q <= '0;
    end else if (clk_en && rise[PIN_FAST]) begin
      fast_div_q <= fast_div_q + FAST_DIV_W'(1); // RQ11
    end
  end

  // Masked and inserted pulses are spread one per 2048-pulse window.
  assign cal_window = cal_cnt_q[CAL_SUB_W-1:0] == '0;
  assign cal_mask   = cal_window && (cal_cnt_q[CAL_W-1:CAL_SUB_W] < cal_minus); // RQ5
  assign kpulse_cal = (raw_pulse && !cal_mask) || ins_pend_q;
  assign kpulse     = kpulse_cal && shift_pend_q == '0; // RQ3
  assign shift_busy = shift_pend_q != '0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cal_cnt_q  <= '0;
      ins_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (raw_pulse)
        cal_cnt_q <= cal_cnt_q + CAL_W'(1);
      ins_pend_q <= raw_pulse && cal_window && cal_plus; // RQ5
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_pend_q <= '0;
    end else if (clk_en) begin
      if (shift_req && !shift_busy)
        shift_pend_q <= shift_count; // RQ3
      else if (shift_busy && kpulse_cal)
        shift_pend_q <= shift_pend_q - SHIFT_W'(1); // RQ3
    end
  end

  // ---------------------------------------------------------------------------
  // Prescaler chain and reference alignment
  // ---------------------------------------------------------------------------
  logic [PREDIV_A_W-1:0] apre_q;
  logic [PREDIV_S_W-1:0] ss_q;
  logic [REF_CNT_W-1:0]  ref_cnt_q;
  logic                  spre_tick, nat_sec, ref_sec, sec_tick;

  assign spre_tick = kpulse && apre_q == '0;
  assign nat_sec   = spre_tick && ss_q == '0;
  assign ref_sec   = rise[PIN_REF] && ref_cnt_q == (ref_60hz ? REF_LAST_60 : REF_LAST_50);
  assign sec_tick  = (ref_detect_en ? ref_sec : nat_sec) ||
                     (shift_req && shift_add_second && !shift_busy); // RQ3
  assign subsecond = ss_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_q <= '0;
    end else if (clk_en && rise[PIN_REF]) begin
      ref_cnt_q <= ref_sec ? '0 : ref_cnt_q + REF_CNT_W'(1); // RQ4
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      apre_q <= '0;
      ss_q   <= '0;
    end else if (clk_en) begin
      // The reference second restarts both stages so the subseconds stay in phase.
      if (time_load || (ref_detect_en && ref_sec)) begin // RQ4
        apre_q <= prediv_a;
        ss_q   <= prediv_s;
      end else if (kpulse) begin
        apre_q <= (apre_q == '0) ? prediv_a : apre_q - PREDIV_A_W'(1); // RQ13
        if (spre_tick)
          ss_q <= (ss_q == '0) ? prediv_s : ss_q - PREDIV_S_W'(1); // RQ13
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Calendar
  // ---------------------------------------------------------------------------
  logic [TIME_W-1:0] time_q;
  logic [DATE_W-1:0] date_q;
  logic [7:0]        sec_v, min_v, hr_v, day_v, mon_v, yr_v;
  logic              pm_v;

  assign sec_v    = {1'b0, time_q[T_SEC_LSB +: SEC_W]};
  assign min_v    = {1'b0, time_q[T_MIN_LSB +: SEC_W]};
  assign hr_v     = {2'b00, time_q[T_HR_LSB +: HR_W]};
  assign pm_v     = time_q[T_PM_BIT];
  assign day_v    = {2'b00, date_q[D_DAY_LSB +: DAY_W]};
  assign mon_v    = {3'b000, date_q[D_MON_LSB +: MON_W]};
  assign yr_v     = date_q[D_YR_LSB +: YR_W];
  assign time_bcd = time_q;
  assign date_bcd = date_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      time_q <= TIME_RST;
      date_q <= DATE_RST;
    end else if (clk_en) begin
      if (time_load) begin
        time_q <= time_load_value;
        date_q <= date_load_value;
      end else if (sec_tick) begin
        time_q[T_SEC_LSB +: SEC_W] <= (sec_v == BCD_59) ? '0 : SEC_W'(bcd_inc(sec_v));     // RQ1
        if (sec_v == BCD_59) begin
          time_q[T_MIN_LSB +: SEC_W] <= (min_v == BCD_59) ? '0 : SEC_W'(bcd_inc(min_v));   // RQ1
          if (min_v == BCD_59) begin
            if (hour_12_mode) begin // RQ1
              if (hr_v == BCD_11) begin
                time_q[T_HR_LSB +: HR_W] <= HR_W'(BCD_12);
                time_q[T_PM_BIT]         <= !pm_v;
              end else begin
                time_q[T_HR_LSB +: HR_W] <= (hr_v == BCD_12) ? HR_W'(BCD_01) : HR_W'(bcd_inc(hr_v));
              end
            end else begin
              time_q[T_HR_LSB +: HR_W] <= (hr_v == BCD_23) ? '0 : HR_W'(bcd_inc(hr_v));
            end
            // Midnight is 23 to 00 in 24-hour form and PM 11 to AM 12 in 12-hour form.
            if (hour_12_mode ? (hr_v == BCD_11 && pm_v) : (hr_v == BCD_23)) begin
              date_q[D_WD_LSB +: WD_W] <= (date_q[D_WD_LSB +: WD_W] == WD_LAST) ? WD_FIRST :
                                          date_q[D_WD_LSB +: WD_W] + WD_W'(1);
              if (day_v == days_in_month(mon_v, yr_v)) begin // RQ2
                date_q[D_DAY_LSB +: DAY_W] <= DAY_W'(BCD_01);
                date_q[D_MON_LSB +: MON_W] <= (mon_v == BCD_12) ? MON_W'(BCD_01) : MON_W'(bcd_inc(mon_v));
                if (mon_v == BCD_12)
                  date_q[D_YR_LSB +: YR_W] <= (yr_v == BCD_99) ? '0 : bcd_inc(yr_v);
              end else begin
                date_q[D_DAY_LSB +: DAY_W] <= DAY_W'(bcd_inc(day_v));
              end
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Tamper filters, timestamp and wakeup timer
  // ---------------------------------------------------------------------------
  logic [TFCNT_W-1:0]  tf_cnt_q [NUM_TAMP];
  logic [NUM_TAMP-1:0] tamp_evt;
  logic [TFCNT_W-1:0]  tf_need;
  logic                ts_evt;

  assign tf_need = TFCNT_W'(1) << tamper_filter;

  always_comb begin
    for (int i = 0; i < NUM_TAMP; i++) begin
      // Filter zero reacts to an edge; otherwise the level must hold for 2^n samples.
      tamp_evt[i] = tamper_en[i] && ((tamper_filter == '0) ? rise[PIN_TAMP + i] :       // RQ6
                    (spre_tick && sync2_q[PIN_TAMP + i] && tf_cnt_q[i] == tf_need - TFCNT_W'(1)));
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_TAMP; i++)
        tf_cnt_q[i] <= '0;
    end else if (clk_en && spre_tick) begin
      for (int i = 0; i < NUM_TAMP; i++) begin
        if (!sync2_q[PIN_TAMP + i])
          tf_cnt_q[i] <= '0; // RQ6
        else if (tf_cnt_q[i] < tf_need)
          tf_cnt_q[i] <= tf_cnt_q[i] + TFCNT_W'(1);
      end
    end
  end

  assign ts_evt = (timestamp_en && rise[PIN_TS]) || (|tamp_evt) || rise[PIN_VBAT];     // RQ7

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ts_time_bcd  <= TIME_RST;
      ts_date_bcd  <= DATE_RST;
      ts_subsecond <= '0;
    end else if (clk_en && ts_evt) begin
      ts_time_bcd  <= time_q; // RQ7
      ts_date_bcd  <= date_q;
      ts_subsecond <= ss_q;
    end
  end

  logic [WAKE_W-1:0]     wake_q;
  logic [WAKE_DIV_W-1:0] wake_div_q;
  logic                  wake_run_q, wake_tick, wake_evt;
  logic [WAKE_W-1:0]     wake_load;

  // Codes 0-3 divide kernel pulses by 16, 8, 4, 2; codes 4-7 count seconds,
  // and 6-7 add 2^16 to the period for the full 17-bit range.
  assign wake_tick = wakeup_clk_sel[2] ? sec_tick :
                     kpulse && (wake_div_q & (WAKE_DIV_W'(4'h8) >> wakeup_clk_sel[1:0])) != '0 &&
                     (wake_div_q & ((WAKE_DIV_W'(4'h8) >> wakeup_clk_sel[1:0]) - WAKE_DIV_W'(1))) == '0;
  assign wake_load = {wakeup_clk_sel[2] & wakeup_clk_sel[1], wakeup_reload};
  assign wake_evt  = wake_run_q && wake_tick && wake_q == '0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_q     <= '0;
      wake_div_q <= '0;
      wake_run_q <= 1'b0;
    end else if (clk_en) begin
      wake_run_q <= wakeup_en;
      if (kpulse)
        wake_div_q <= wake_div_q + WAKE_DIV_W'(1);
      if (!wake_run_q)
        wake_q <= wake_load; // RQ8
      else if (wake_tick)
        wake_q <= (wake_q == '0) ? wake_load : wake_q - WAKE_W'(1); // RQ8
    end
  end

  // ---------------------------------------------------------------------------
  // Alarms, event flags and requests
  // ---------------------------------------------------------------------------
  logic                 tick_d1_q;
  logic [NUM_FLAGS-1:0] events;
  logic [NUM_FLAGS-1:0] flags_q;

  always_comb begin
    events                       = '0;
    events[FLG_ALRA]             = tick_d1_q && alarm_a_en && time_q == alarm_a_value;
    events[FLG_ALRB]             = tick_d1_q && alarm_b_en && time_q == alarm_b_value;
    events[FLG_WAKE]             = wake_evt;
    events[FLG_TS]               = ts_evt;
    events[FLG_TAMP +: NUM_TAMP] = tamp_evt;
  end

  assign flags = flags_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_d1_q  <= 1'b0;
      flags_q    <= '0;
      irq        <= 1'b0;
      wakeup_req <= 1'b0;
    end else if (clk_en) begin
      tick_d1_q  <= sec_tick || time_load;
      // A new event wins over a clear in the same cycle.
      flags_q    <= (flags_q & ~flag_clear) | events; // RQ12
      irq        <= |(((flags_q & ~flag_clear) | events) & irq_en); // RQ12
      wakeup_req <= |(events & irq_en); // RQ12
    end
  end

  // ---------------------------------------------------------------------------
  // Backup store
  // ---------------------------------------------------------------------------
  // reset_n is the backup-domain reset; system resets never reach this block.
  logic [BKP_DW-1:0] bkp_mem [BKP_DEPTH];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < BKP_DEPTH; i++)
        bkp_mem[i] <= '0; // RQ10
    end else if (clk_en && backup_we) begin
      bkp_mem[backup_addr] <= backup_wdata; // RQ9
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      backup_rdata <= '0;
    else if (clk_en)
      backup_rdata <= bkp_mem[backup_addr]; // RQ9
  end

endmodule // bcd_calendar_rtc_backup

// >>> verif/rtc_props.sv
// Port-level assertions for the BCD calendar clock.
`timescale 1ns/1ps
module rtc_props import rtc_pkg::*; (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic                 time_load,
  input wire logic [TIME_W-1:0]    time_load_value,
  input wire logic [DATE_W-1:0]    date_load_value,
  input wire logic                 shift_req,
  input wire logic [NUM_FLAGS-1:0] irq_en,
  input wire logic [NUM_FLAGS-1:0] flag_clear,
  input wire logic                 backup_we,
  input wire logic [BKP_AW-1:0]    backup_addr,
  input wire logic [BKP_DW-1:0]    backup_wdata,
  input wire logic [BKP_DW-1:0]    backup_rdata,
  input wire logic [TIME_W-1:0]    time_bcd,
  input wire logic [DATE_W-1:0]    date_bcd,
  input wire logic [TIME_W-1:0]    ts_time_bcd,
  input wire logic [NUM_FLAGS-1:0] flags,
  input wire logic                 shift_busy,
  input wire logic                 irq,
  input wire logic                 wakeup_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence load_s; time_load; endsequence
  sequence shift_go_s; shift_req && !shift_busy; endsequence
  property bkp_p;
    logic [BKP_DW-1:0] d;
    (backup_we, d = backup_wdata) ##1 (!backup_we && backup_addr == $past(backup_addr)) |=> backup_rdata == d;
  endproperty
  backup_read_a:
    assert property (bkp_p) else $error("backup word lost");
  time_load_a:
    assert property (load_s |=> time_bcd == $past(time_load_value) && date_bcd == $past(date_load_value))
      else $error("calendar load not applied");
  time_digits_a:
    assert property (time_bcd[3:0] <= 4'h9 && time_bcd[6:0] <= 7'h59 && time_bcd[13:7] <= 7'h59
      && time_bcd[17:14] <= 4'h9) else $error("time field not BCD");
  date_range_a:
    assert property (date_bcd[5:0] inside {[6'h01:6'h31]} && date_bcd[13:9] inside {[5'h01:5'h12]})
      else $error("date field out of range");
  flags_sticky_a:
    assert property ((flags & $past(flags & ~flag_clear)) == $past(flags & ~flag_clear)) else $error("flag lost");
  irq_level_a:
    assert property (irq == |(flags & $past(irq_en))) else $error("irq not tied to flags");
  wake_pulse_a:
    assert property (wakeup_req |=> !wakeup_req) else $error("wakeup request too long");
  stamp_copy_a:
    assert property ($rose(flags[FLG_TS]) |-> ts_time_bcd == $past(time_bcd)) else $error("stamp mismatch");
  shift_busy_a:
    assert property (shift_go_s |=> shift_busy) else $error("shift not started");
endmodule // rtc_props
bind bcd_calendar_rtc_backup rtc_props u_props (.*);

// >>> verif/bcd_calendar_rtc_backup_tb.sv
// Self-checking bench for the BCD calendar clock.
`timescale 1ns/1ps
module bcd_calendar_rtc_backup_tb;
  import rtc_pkg::*;
  logic clk_sys, reset_n, clk_en, low_speed_crystal_clock, low_speed_internal_rc_clock, high_speed_external_clock;
  logic hour_12_mode, time_load, shift_req, shift_add_second, ref_detect_en, ref_60hz, ref_clock_pin, cal_plus;
  logic alarm_a_en, alarm_b_en, timestamp_pin, timestamp_en, vbat_switch_pin, wakeup_en, backup_we;
  logic shift_busy, irq, wakeup_req;
  logic [1:0] clk_sel;
  logic [FILT_W-1:0] tamper_filter;
  logic [PREDIV_A_W-1:0] prediv_a;
  logic [PREDIV_S_W-1:0] prediv_s, subsecond, ts_subsecond;
  logic [SHIFT_W-1:0] shift_count;
  logic [CALM_W-1:0] cal_minus;
  logic [TIME_W-1:0] time_load_value, alarm_a_value, alarm_b_value, time_bcd, ts_time_bcd;
  logic [DATE_W-1:0] date_load_value, date_bcd, ts_date_bcd;
  logic [NUM_TAMP-1:0] tamper_pin, tamper_en;
  logic [WAKE_SEL_W-1:0] wakeup_clk_sel;
  logic [WAKE_RELOAD_W-1:0] wakeup_reload;
  logic [NUM_FLAGS-1:0] flag_clear, irq_en, flags;
  logic [BKP_AW-1:0] backup_addr;
  logic [BKP_DW-1:0] backup_wdata, backup_rdata;
  logic [31:0] exp_q[$], bk[4], e;
  int id_q[$], n_fail, num_checks, seed, i, m;
  event look;
  localparam logic [TIME_W-1:0] T_END = 21'h08ecd9; // 23:59:59
  localparam logic [TIME_W-1:0] T_AM = 21'h046cd9; // 11:59:59 AM
  bcd_calendar_rtc_backup dut (.*);
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [DATE_W-1:0] mk_d(input logic [7:0] y, mo, input logic [2:0] w, input logic [7:0] d);
    return {y, mo[4:0], w, d[5:0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic note(input int id, input logic [31:0] x);
    id_q.push_back(id);
    exp_q.push_back(x);
    -> look;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
    num_checks++;
    if (seen !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, seen);
    end
  endtask
  // The divided fast source gives one kernel pulse per 32 edges.
  task automatic kpulse;
    repeat (clk_sel == 2'h3 ? 32 : 1) begin
      {low_speed_crystal_clock, low_speed_internal_rc_clock, high_speed_external_clock} = 3'h7;
      cyc(3);
      {low_speed_crystal_clock, low_speed_internal_rc_clock, high_speed_external_clock} = 3'h0;
      cyc(3);
    end
    cyc(3);
  endtask
  task automatic load(input logic [TIME_W-1:0] t, input logic [DATE_W-1:0] d);
    time_load_value = t;
    date_load_value = d;
    time_load = 1;
    cyc(1);
    time_load = 0;
    cyc(1);
  endtask
  task automatic clr;
    flag_clear = '1;
    cyc(1);
    flag_clear = '0;
  endtask
  task automatic roll(input logic [1:0] s, input logic [TIME_W-1:0] t, tn, input logic [DATE_W-1:0] d, dn);
    clk_sel = s;
    load(t, d);
    kpulse;
    note(0, 32'(tn));
    note(1, 32'(dn));
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(look) begin
    while (id_q.size() > 0) begin
      m = id_q.pop_front();
      e = exp_q.pop_front();
      case (m)
        0: check("time_bcd", 32'(time_bcd), e);
        1: check("date_bcd", 32'(date_bcd), e);
        2: check("backup_rdata", backup_rdata, e);
        3: check("flags", 32'(flags), e);
        4: check("ts_time_bcd", 32'(ts_time_bcd), e);
        5: check("shift_busy", 32'(shift_busy), e);
        6: check("irq", 32'(irq), e);
        7: check("wakeup_flag", 32'(flags[FLG_WAKE]), e);
        8: check("stamp_flag", 32'(flags[FLG_TS]), e);
        default: check("tamper_flag", 32'(flags[FLG_TAMP]), e);
      endcase
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 70153;
    {reset_n, clk_sel, low_speed_crystal_clock, low_speed_internal_rc_clock, high_speed_external_clock, prediv_a,
     prediv_s, hour_12_mode, time_load, time_load_value, date_load_value, shift_req, shift_add_second, shift_count,
     ref_detect_en, ref_60hz, ref_clock_pin, cal_plus, cal_minus, alarm_a_en, alarm_a_value, alarm_b_en, alarm_b_value,
     tamper_pin, tamper_en, tamper_filter, timestamp_pin, timestamp_en, vbat_switch_pin, wakeup_en, wakeup_clk_sel,
     wakeup_reload, flag_clear, irq_en, backup_we, backup_addr, backup_wdata} = '0;
    clk_en = 1;
    cyc(2);
    reset_n = 1;
    cyc(1);
    note(0, 0);
    note(1, 32'(DATE_RST));
    for (i = 0; i < 4; i++) begin
      bk[i] = $random(seed);
      backup_we = 1;
      backup_addr = 5'(i * 9);
      backup_wdata = bk[i];
      cyc(1);
      backup_we = 0;
      cyc(1);
      note(2, bk[i]);
    end
    for (i = 0; i < 4; i++) begin
      backup_addr = 5'(i * 9);
      cyc(1);
      note(2, bk[i]);
    end
    alarm_a_en = 1;
    irq_en = 7'h05;
    roll(2'h1, T_END, 21'h0, mk_d(8'h00, 8'h02, 3'h7, 8'h28), mk_d(8'h00, 8'h02, 3'h1, 8'h29));
    note(3, 32'h1);
    note(6, 1);
    clr;
    cyc(1);
    note(3, 0);
    note(6, 0);
    roll(2'h2, T_END, 21'h0, mk_d(8'h01, 8'h02, 3'h3, 8'h28), mk_d(8'h01, 8'h03, 3'h4, 8'h01));
    roll(2'h3, T_END, 21'h0, mk_d(8'h01, 8'h04, 3'h1, 8'h30), mk_d(8'h01, 8'h05, 3'h2, 8'h01));
    roll(2'h1, T_END, 21'h0, mk_d(8'h99, 8'h12, 3'h5, 8'h31), mk_d(8'h00, 8'h01, 3'h6, 8'h01));
    hour_12_mode = 1;
    roll(2'h2, T_AM, 21'h148000, mk_d(8'h00, 8'h01, 3'h2, 8'h31), mk_d(8'h00, 8'h01, 3'h2, 8'h31));
    hour_12_mode = 0;
    clk_sel = 2'h1;
    wakeup_clk_sel = 3'h4;
    wakeup_reload = 16'h0001;
    cyc(2);
    wakeup_en = 1;
    cyc(2);
    clr;
    kpulse;
    note(7, 0);
    kpulse;
    note(7, 1);
    clr;
    timestamp_en = 1;
    load(T_END, DATE_RST);
    timestamp_pin = 1;
    cyc(6);
    note(4, 32'(T_END));
    note(8, 1);
    clr;
    timestamp_en = 0;
    timestamp_pin = 0;
    load(T_AM, DATE_RST);
    vbat_switch_pin = 1;
    cyc(6);
    note(4, 32'(T_AM));
    note(8, 1);
    clr;
    tamper_en = 3'h1;
    load(T_END, DATE_RST);
    tamper_pin = 3'h1;
    cyc(6);
    note(9, 1);
    note(4, 32'(T_END));
    load(T_END, DATE_RST);
    shift_count = 15'h0002;
    shift_req = 1;
    cyc(1);
    shift_req = 0;
    cyc(1);
    note(5, 1);
    kpulse;
    note(5, 1);
    kpulse;
    note(5, 0);
    note(0, 32'(T_END));
    cyc(2);
    end_of_test;
  end
endmodule // bcd_calendar_rtc_backup_tb
